//--- design/mbl_memory_bank_latch.sv
// Write-only memory bank latch together with the external memory address decoder
// and the supply supervisor reset that guards battery-backed RAM.
// Assumes host bus strobes and supply_ok_i are synchronous to clock_i.
`timescale 1ns/1ns

// How it works
// (RULE1) The latch cannot be read; software keeps its own shadow copy.
// (RULE2) System reset clears every latch output to low.
// (RULE3) A data write to the decoded latch address loads the written byte.
// (RULE4) Bit 0 picks expansion RAM when high, socket device when low.
// (RULE5) Bit 1 high blocks main RAM, expansion RAM and socket chip enables.
// (RULE6) Bit 2 swaps code and data spaces so flash can be written.
// (RULE7) Bits 3 and 4 drive the expansion RAM upper address lines.
// (RULE8) Bit 5 drives the top address line of the code memory device.
// (RULE9) A configuration input selects memory mode zero or mode one.
// (RULE10) The decoder makes every memory enable over the whole address range.
// (RULE11) Supply failure drops the supervisory reset at once and deselects RAM.
// (RULE12) After power-up the supervisory reset stays low for a short interval.
// (RULE13) Code below 2000h is internal unless all fetches are forced external; the code also sends it to main RAM while bit 2 swaps the spaces.
// (RULE14) Software disables RAM before power-down or idle, only from EPROM.
// (RULE15) Software sets the disable bit via shadow OR 02h, clears via AND FDh.
// (RULE16) All outputs change together at the write strobe's end; bits 6, 7 unused.
// (RULE17) Writes elsewhere leave the latch untouched.
module mbl_memory_bank_latch #(
    parameter int unsigned HOLD_CYCLES = mbl_pkg::MBL_HOLD_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire mbl_pkg::mbl_bus_t bus_i,
    input wire logic ext_code_only_i,
    input wire logic config_high_i,
    input wire logic supply_ok_i,
    output mbl_pkg::mbl_sel_t sel_o,
    output logic socket_bank_select_o,
    output logic memory_disable_o,
    output logic flash_program_swap_o,
    output logic ram_bank_addr_lo_o,
    output logic ram_bank_addr_hi_o,
    output logic flash_bank_addr_o,
    output logic supply_fail_reset_n_o
);
    import mbl_pkg::*;

    typedef struct packed {
        logic [MBL_LATCH_W-1:0] latch;
        logic wr_prev;
        logic hit;
        logic [MBL_LATCH_W-1:0] data;
        mbl_sup_t sup;
        logic [MBL_CNT_W-1:0] cnt;
    } mbl_state_t;

    mbl_state_t state_q;
    mbl_state_t state_d;
    mbl_tgt_t tgt;
    logic data_acc;
    logic active;
    logic ram_ok;
    logic blk;
    logic eff_code;
    logic wr_end;

    // Code decode; mode one maps the lower half of code space not taken by the internal ROM onto main RAM.
    function automatic mbl_tgt_t mbl_decode(input logic [15:0] a, input logic code,
                                            input logic mode, input logic ext_only);
        mbl_tgt_t t;
        t = MBL_T_NONE;
        if (code) begin
            if (!ext_only && a < MBL_INT_ROM_TOP) begin
                t = MBL_T_INT_ROM;
            end else if (mode && a < MBL_WINDOW_BASE) begin
                t = MBL_T_MAIN_RAM;
            end else begin
                t = MBL_T_CODE_DEV;
            end
        end else if (a == MBL_LATCH_ADDR) begin
            t = MBL_T_LATCH;
        end else if (a >= MBL_IO_BASE) begin
            t = MBL_T_IO;
        end else if (a < MBL_WINDOW_BASE) begin
            t = MBL_T_MAIN_RAM;
        end else begin
            t = MBL_T_WINDOW;
        end
        return t;
    endfunction

    always_comb begin
        data_acc = bus_i.rd | bus_i.wr;
        active = data_acc | bus_i.code;
        // The I/O area stays in data space during a swap so the latch can be cleared.
        eff_code = bus_i.code ^ state_q.latch[MBL_BIT_SWAP];
        if (data_acc && !bus_i.code && bus_i.addr >= MBL_IO_BASE) begin
            tgt = mbl_decode(bus_i.addr, 1'b0, config_high_i, ext_code_only_i); // RULE9
        end else begin
            tgt = mbl_decode(bus_i.addr, eff_code, config_high_i, ext_code_only_i); // RULE6
        end
        ram_ok = (state_q.sup == MBL_SUP_OK);
        blk = state_q.latch[MBL_BIT_MDIS] | !supply_ok_i | !ram_ok;
        wr_end = state_q.wr_prev & !bus_i.wr;
    end

    always_comb begin
        sel_o.main_ram_ce_n = !(active && tgt == MBL_T_MAIN_RAM && !blk); // RULE5 RULE10
        sel_o.exp_ram_ce_n = !(active && tgt == MBL_T_WINDOW && !blk
                               && state_q.latch[MBL_BIT_BANK]); // RULE4
        sel_o.socket_ce_n = !(active && tgt == MBL_T_WINDOW && !blk
                              && !state_q.latch[MBL_BIT_BANK]); // RULE4
        sel_o.code_ce_n = !(active && tgt == MBL_T_CODE_DEV); // RULE10
        sel_o.int_rom_sel = active && tgt == MBL_T_INT_ROM; // RULE13
        // Reads of the latch select nothing, so no value ever returns.
        sel_o.latch_sel = bus_i.wr && !bus_i.code && tgt == MBL_T_LATCH; // RULE1 RULE3
        sel_o.io_sel = data_acc && !bus_i.code && tgt == MBL_T_IO;
    end

    always_comb begin
        state_d = state_q;
        state_d.wr_prev = bus_i.wr;
        if (bus_i.wr) begin
            state_d.hit = sel_o.latch_sel;
            state_d.data = bus_i.data[MBL_LATCH_W-1:0]; // RULE16
        end
        // Loading at the strobe's end lets every output move in the same cycle.
        if (wr_end && state_q.hit) begin
            state_d.latch = state_q.data; // RULE3 RULE16 RULE17
        end
        case (state_q.sup)
            MBL_SUP_FAIL: begin
                state_d.cnt = '0;
                if (supply_ok_i) begin
                    state_d.sup = MBL_SUP_HOLD;
                end
            end
            MBL_SUP_HOLD: begin
                state_d.cnt = state_q.cnt + 1'b1;
                if (!supply_ok_i) begin
                    state_d.sup = MBL_SUP_FAIL; // RULE11
                end else if (state_q.cnt == MBL_CNT_W'(HOLD_CYCLES - 1)) begin
                    state_d.sup = MBL_SUP_OK; // RULE12
                end
            end
            MBL_SUP_OK: begin
                if (!supply_ok_i) begin
                    state_d.sup = MBL_SUP_FAIL; // RULE11
                end
            end
            default: begin
                state_d.sup = MBL_SUP_FAIL;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q.latch <= MBL_LATCH_RESET; // RULE2
            state_q.wr_prev <= 1'b0;
            state_q.hit <= 1'b0;
            state_q.data <= '0;
            state_q.sup <= MBL_SUP_FAIL;
            state_q.cnt <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign socket_bank_select_o = state_q.latch[MBL_BIT_BANK]; // RULE4
    assign memory_disable_o = state_q.latch[MBL_BIT_MDIS]; // RULE5
    assign flash_program_swap_o = state_q.latch[MBL_BIT_SWAP]; // RULE6
    assign ram_bank_addr_lo_o = state_q.latch[MBL_BIT_RLO]; // RULE7
    assign ram_bank_addr_hi_o = state_q.latch[MBL_BIT_RHI]; // RULE7
    assign flash_bank_addr_o = state_q.latch[MBL_BIT_FLB]; // RULE8
    // Combinational with supply_ok_i so a failing supply pulls it low in the same cycle.
    assign supply_fail_reset_n_o = supply_ok_i && ram_ok; // RULE11 RULE12

    logic [MBL_LATCH_W-1:0] outs;
    assign outs = {flash_bank_addr_o, ram_bank_addr_hi_o, ram_bank_addr_lo_o,
                   flash_program_swap_o, memory_disable_o, socket_bank_select_o};

    sequence s_latch_write;
        bus_i.wr && sel_o.latch_sel ##1 !bus_i.wr;
    endsequence

    sequence s_other_write;
        bus_i.wr && !sel_o.latch_sel ##1 !bus_i.wr;
    endsequence

    AST_RESET_CLEARS: assert property (@(posedge clock_i) // RULE2
        reset_i |=> outs == '0 && !memory_disable_o)
        else $error("Latch outputs not low after reset.");

    AST_LATCH_LOAD: assert property (@(posedge clock_i) disable iff (reset_i) // RULE3
        (bus_i.wr && sel_o.latch_sel) ##1 (!bus_i.wr && !$past(reset_i))
        |=> outs == $past(bus_i.data[MBL_LATCH_W-1:0], 2))
        else $error("Latch did not take the written byte.");

    AST_HOLD_DURING_STROBE: assert property (@(posedge clock_i) disable iff (reset_i) // RULE16
        bus_i.wr && state_q.wr_prev |=> $stable(outs))
        else $error("Latch outputs changed before the strobe ended.");

    AST_OTHER_WRITE: assert property (@(posedge clock_i) disable iff (reset_i) // RULE17
        s_other_write |=> $stable(outs))
        else $error("Write to another address altered the latch.");

    AST_MDIS_BLOCKS: assert property (@(posedge clock_i) disable iff (reset_i) // RULE5
        memory_disable_o |-> sel_o.main_ram_ce_n && sel_o.exp_ram_ce_n && sel_o.socket_ce_n)
        else $error("A RAM enable went active while memory is disabled.");

    AST_BANK_SELECT: assert property (@(posedge clock_i) disable iff (reset_i) // RULE4
        !sel_o.socket_ce_n |-> !socket_bank_select_o && sel_o.exp_ram_ce_n)
        else $error("Socket enabled while the expansion RAM bank is chosen.");

    AST_SUPPLY_DROP: assert property (@(posedge clock_i) disable iff (reset_i) // RULE11
        !supply_ok_i |-> !supply_fail_reset_n_o && sel_o.main_ram_ce_n
        ##1 !supply_fail_reset_n_o[*2])
        else $error("Supply failure did not drop the reset and deselect RAM.");

    logic [MBL_CNT_W-1:0] up_cnt;
    always_ff @(posedge clock_i) begin
        if (reset_i || !supply_ok_i) begin
            up_cnt <= '0;
        end else if (!supply_fail_reset_n_o) begin
            up_cnt <= up_cnt + 1'b1;
        end
    end

    AST_POWER_UP_HOLD: assert property (@(posedge clock_i) disable iff (reset_i) // RULE12
        $rose(supply_fail_reset_n_o) |-> up_cnt == MBL_CNT_W'(HOLD_CYCLES + 1))
        else $error("Power-up reset interval has the wrong length.");

    AST_INT_ROM: assert property (@(posedge clock_i) disable iff (reset_i) // RULE13
        bus_i.code && !flash_program_swap_o && bus_i.addr < MBL_INT_ROM_TOP
        |-> sel_o.int_rom_sel == !ext_code_only_i
        && sel_o.code_ce_n == !(ext_code_only_i && !config_high_i))
        else $error("Low code fetch went to the wrong source.");

    AST_SWAP: assert property (@(posedge clock_i) disable iff (reset_i) // RULE6
        flash_program_swap_o && bus_i.wr && !bus_i.code && bus_i.addr >= MBL_WINDOW_BASE
        && bus_i.addr < MBL_IO_BASE |-> !sel_o.code_ce_n && sel_o.exp_ram_ce_n)
        else $error("Data write did not reach the code device during swap.");

    AST_NO_READ: assert property (@(posedge clock_i) disable iff (reset_i) // RULE1
        bus_i.rd && !bus_i.wr |-> !sel_o.latch_sel)
        else $error("Latch selected on a read.");

    AST_FLASH_BANK: assert property (@(posedge clock_i) disable iff (reset_i) // RULE8
        s_latch_write |=> flash_bank_addr_o == $past(bus_i.data[MBL_BIT_FLB], 2))
        else $error("Flash bank address does not follow bit 5.");

    // Only a plain code fetch counts here, since a swapped data access decodes differently.
    sequence s_mode_one_fetch;
        bus_i.code && !bus_i.rd && !bus_i.wr && !flash_program_swap_o && config_high_i
        && bus_i.addr >= MBL_INT_ROM_TOP && bus_i.addr < MBL_WINDOW_BASE;
    endsequence

    AST_MODE_ONE: assert property (@(posedge clock_i) disable iff (reset_i) // RULE9
        s_mode_one_fetch |-> sel_o.code_ce_n
        && sel_o.main_ram_ce_n == (memory_disable_o || !supply_fail_reset_n_o))
        else $error("Mode one fetch did not go to main RAM.");

    AST_CODE_HIGH: assert property (@(posedge clock_i) disable iff (reset_i) // RULE13
        bus_i.code && !bus_i.rd && !bus_i.wr && !flash_program_swap_o
        && bus_i.addr >= MBL_WINDOW_BASE |-> !sel_o.code_ce_n)
        else $error("High code fetch missed the code device.");

    AST_IO_SELECT: assert property (@(posedge clock_i) disable iff (reset_i) // RULE10
        (bus_i.rd || bus_i.wr) && !bus_i.code && bus_i.addr >= MBL_IO_BASE
        && bus_i.addr != MBL_LATCH_ADDR |-> sel_o.io_sel && sel_o.main_ram_ce_n && sel_o.code_ce_n)
        else $error("I/O access was not routed to the I/O area.");

    AST_ONE_TARGET: assert property (@(posedge clock_i) disable iff (reset_i) // RULE10
        $onehot0({!sel_o.main_ram_ce_n, !sel_o.exp_ram_ce_n, !sel_o.socket_ce_n,
                  !sel_o.code_ce_n, sel_o.int_rom_sel, sel_o.latch_sel, sel_o.io_sel}))
        else $error("More than one memory device enabled at once.");

    AST_IDLE_QUIET: assert property (@(posedge clock_i) disable iff (reset_i) // RULE10
        !bus_i.rd && !bus_i.wr && !bus_i.code |-> sel_o == mbl_sel_t'(7'h78))
        else $error("An enable went active with no bus cycle.");

    AST_EXP_BANK: assert property (@(posedge clock_i) disable iff (reset_i) // RULE4
        !sel_o.exp_ram_ce_n |-> socket_bank_select_o && sel_o.socket_ce_n)
        else $error("Expansion RAM enabled while the socket bank is chosen.");

    AST_RESET_N_BLOCKS: assert property (@(posedge clock_i) disable iff (reset_i) // RULE11
        !supply_fail_reset_n_o
        |-> sel_o.main_ram_ce_n && sel_o.exp_ram_ce_n && sel_o.socket_ce_n)
        else $error("A RAM enable went active while the supervisory reset is low.");

    AST_BANK_LOAD: assert property (@(posedge clock_i) disable iff (reset_i) // RULE4
        s_latch_write |=> socket_bank_select_o == $past(bus_i.data[MBL_BIT_BANK], 2))
        else $error("Bank select does not follow bit 0.");

    AST_MDIS_LOAD: assert property (@(posedge clock_i) disable iff (reset_i) // RULE5
        s_latch_write |=> memory_disable_o == $past(bus_i.data[MBL_BIT_MDIS], 2))
        else $error("Memory disable does not follow bit 1.");

    AST_SWAP_LOAD: assert property (@(posedge clock_i) disable iff (reset_i) // RULE6
        s_latch_write |=> flash_program_swap_o == $past(bus_i.data[MBL_BIT_SWAP], 2))
        else $error("Space swap does not follow bit 2.");

    AST_RAM_BANK_LOAD: assert property (@(posedge clock_i) disable iff (reset_i) // RULE7
        s_latch_write |=> {ram_bank_addr_hi_o, ram_bank_addr_lo_o}
        == $past(bus_i.data[MBL_BIT_RHI:MBL_BIT_RLO], 2))
        else $error("RAM bank address does not follow bits 3 and 4.");

    AST_RESET_SUPERVISOR: assert property (@(posedge clock_i) // RULE12
        reset_i |=> !supply_fail_reset_n_o)
        else $error("Supervisory reset not low after system reset.");

    AST_HOLD_BOUND: assert property (@(posedge clock_i) disable iff (reset_i) // RULE12
        !supply_fail_reset_n_o |-> up_cnt <= MBL_CNT_W'(HOLD_CYCLES + 1))
        else $error("Power-up reset held longer than the hold interval.");
endmodule // mbl_memory_bank_latch

//--- design/mbl_pkg.sv
// Constants and types shared by the memory bank latch and its address decoder.
// Assumes a single 25 MHz clock and a 16-bit external address bus.
package mbl_pkg;
    localparam int unsigned MBL_CLOCK_KHZ = 25000;
    localparam int unsigned MBL_HOLD_TIME_US = 200;
    localparam int unsigned MBL_HOLD_CYCLES = (MBL_HOLD_TIME_US * MBL_CLOCK_KHZ + 999) / 1000;
    localparam int unsigned MBL_CNT_W = 16;

    localparam logic [15:0] MBL_INT_ROM_TOP = 16'h2000;
    localparam logic [15:0] MBL_WINDOW_BASE = 16'h8000;
    localparam logic [15:0] MBL_IO_BASE = 16'hff00;
    localparam logic [15:0] MBL_LATCH_ADDR = 16'hffc0;

    localparam int unsigned MBL_BIT_BANK = 0;
    localparam int unsigned MBL_BIT_MDIS = 1;
    localparam int unsigned MBL_BIT_SWAP = 2;
    localparam int unsigned MBL_BIT_RLO = 3;
    localparam int unsigned MBL_BIT_RHI = 4;
    localparam int unsigned MBL_BIT_FLB = 5;
    localparam int unsigned MBL_LATCH_W = 6;
    localparam logic [5:0] MBL_LATCH_RESET = 6'h00;

    typedef enum logic [1:0] {
        MBL_SUP_FAIL = 2'b00,
        MBL_SUP_HOLD = 2'b01,
        MBL_SUP_OK = 2'b11
    } mbl_sup_t;

    typedef enum logic [2:0] {
        MBL_T_NONE = 3'h0,
        MBL_T_INT_ROM = 3'h1,
        MBL_T_CODE_DEV = 3'h2,
        MBL_T_MAIN_RAM = 3'h3,
        MBL_T_WINDOW = 3'h4,
        MBL_T_LATCH = 3'h5,
        MBL_T_IO = 3'h6
    } mbl_tgt_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
        logic code;
    } mbl_bus_t;

    typedef struct packed {
        logic main_ram_ce_n;
        logic exp_ram_ce_n;
        logic socket_ce_n;
        logic code_ce_n;
        logic int_rom_sel;
        logic latch_sel;
        logic io_sel;
    } mbl_sel_t;
endpackage

//--- verification/mbl_host_model.sv
// Host core model: makes external data writes, data reads and code fetches.
// Assumes one caller at a time; every change lands on a falling clock edge.
`timescale 1ns/1ns
module mbl_host_model (
    input wire logic clock_i,
    output mbl_pkg::mbl_bus_t bus_o
);
    import mbl_pkg::*;
    logic [7:0] shadow_q;
    initial begin
        bus_o = '{addr: 16'h5a5a, data: 8'ha5, wr: 1'b0, rd: 1'b0, code: 1'b0};
        shadow_q = 8'h00;
    end
    task automatic put(input logic [15:0] a, input logic [7:0] d, input logic [2:0] s);
        @(negedge clock_i);
        bus_o <= '{addr: a, data: d, wr: s[2], rd: s[1], code: s[0]};
    endtask
    // Released lines do not keep the old value, so stale data cannot pass.
    task automatic idle;
        @(negedge clock_i);
        bus_o <= '{addr: ~bus_o.addr, data: ~bus_o.data, wr: 1'b0, rd: 1'b0, code: 1'b0};
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        put(a, d, 3'b100);
        idle;
        repeat (2) @(negedge clock_i);
        if (a == MBL_LATCH_ADDR) begin
            shadow_q = d;
        end
    endtask
    // Only the shadow tells the present state, since the latch cannot be read.
    task automatic mem_off;
        shadow_q = shadow_q | 8'h02;
        wr(MBL_LATCH_ADDR, shadow_q);
    endtask
    task automatic mem_on;
        shadow_q = shadow_q & 8'hfd;
        wr(MBL_LATCH_ADDR, shadow_q);
    endtask
endmodule // mbl_host_model

//--- verification/tb_memory_bank_latch.sv
// Self-checking bench for the bank latch, decoder and supply supervisor.
// Assumes the host model drives the bus and HOLD_CYCLES is cut to 8.
`timescale 1ns/1ns
module tb_memory_bank_latch;
    import mbl_pkg::*;
    logic clock_i;
    logic reset_i = 1'b1;
    logic ext = 1'b0;
    logic cfg = 1'b0;
    logic sup = 1'b1;
    mbl_bus_t bus;
    mbl_sel_t sel;
    wire logic [5:0] lat;
    logic rn;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    mbl_host_model mbl_host_model_i (.clock_i(clock_i), .bus_o(bus));
    mbl_memory_bank_latch #(.HOLD_CYCLES(8)) mbl_memory_bank_latch_i (
        .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus), .ext_code_only_i(ext),
        .config_high_i(cfg), .supply_ok_i(sup), .sel_o(sel),
        .socket_bank_select_o(lat[0]), .memory_disable_o(lat[1]),
        .flash_program_swap_o(lat[2]), .ram_bank_addr_lo_o(lat[3]),
        .ram_bank_addr_hi_o(lat[4]), .flash_bank_addr_o(lat[5]),
        .supply_fail_reset_n_o(rn)
    );
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Enables are combinational, so they are looked at while the request stands.
    task automatic look(input logic [15:0] a, input logic [2:0] s, input logic [6:0] e);
        mbl_host_model_i.put(a, 8'h00, s);
        #5;
        chk("sel", sel, e);
        mbl_host_model_i.idle;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (16) @(negedge clock_i);
        chk("latch", lat, 6'h00);
        reset_i = 1'b0;
        repeat (7) @(negedge clock_i);
        chk("rst_n", rn, 1'b0);
        repeat (5) @(negedge clock_i);
        chk("rst_n", rn, 1'b1);
        look(16'h1234, 3'b010, 7'b0111000);
        look(16'h8000, 3'b010, 7'b1101000);
        look(16'hff10, 3'b010, 7'b1111001);
        look(16'h0100, 3'b001, 7'b1111100);
        ext = 1'b1;
        look(16'h0100, 3'b001, 7'b1110000);
        ext = 1'b0;
        cfg = 1'b1;
        look(16'h3000, 3'b001, 7'b0111000);
        cfg = 1'b0;
        look(16'h3000, 3'b001, 7'b1110000);
        look(16'h9000, 3'b001, 7'b1110000);
        mbl_host_model_i.put(MBL_LATCH_ADDR, 8'h2a, 3'b100);
        mbl_host_model_i.idle;
        chk("latch", lat, 6'h00);
        @(negedge clock_i);
        chk("latch", lat, 6'h2a);
        // A strobe held over two cycles keeps the latch still, and its last byte wins.
        mbl_host_model_i.put(MBL_LATCH_ADDR, 8'h15, 3'b100);
        mbl_host_model_i.put(MBL_LATCH_ADDR, 8'h0a, 3'b100);
        mbl_host_model_i.idle;
        chk("latch", lat, 6'h2a);
        @(negedge clock_i);
        chk("latch", lat, 6'h0a);
        mbl_host_model_i.wr(MBL_LATCH_ADDR, 8'h01);
        look(16'h8000, 3'b010, 7'b1011000);
        mbl_host_model_i.mem_off;
        chk("latch", lat, 6'h03);
        look(16'h1234, 3'b010, 7'b1111000);
        look(16'h8000, 3'b010, 7'b1111000);
        mbl_host_model_i.mem_on;
        chk("latch", lat, 6'h01);
        mbl_host_model_i.wr(16'hffc1, 8'h00);
        mbl_host_model_i.wr(16'h7fc0, 8'h00);
        look(MBL_LATCH_ADDR, 3'b010, 7'b1111000);
        chk("latch", lat, 6'h01);
        mbl_host_model_i.wr(MBL_LATCH_ADDR, 8'h04);
        look(16'h4000, 3'b010, 7'b1110000);
        look(16'h4000, 3'b001, 7'b0111000);
        look(16'h8000, 3'b100, 7'b1110000);
        for (int n = 0; n < 6; n++) begin
            mbl_host_model_i.wr(MBL_LATCH_ADDR, 8'hc0 | (8'h01 << n));
            chk("latch", lat, 6'h01 << n);
        end
        mbl_host_model_i.wr(MBL_LATCH_ADDR, 8'hff);
        chk("latch", lat, 6'h3f);
        mbl_host_model_i.wr(MBL_LATCH_ADDR, 8'h00);
        sup = 1'b0;
        look(16'h1234, 3'b010, 7'b1111000);
        chk("rst_n", rn, 1'b0);
        sup = 1'b1;
        repeat (12) @(negedge clock_i);
        chk("rst_n", rn, 1'b1);
        reset_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk("latch", lat, 6'h00);
        chk("rst_n", rn, 1'b0);
        reset_i = 1'b0;
        tally_and_finish;
    end
endmodule // tb_memory_bank_latch
